// File: dct_host_end.sv
`timescale 1ns/100ps
`default_nettype none
module dct_host_end #(
  parameter int HALF = dct_pkg::LINK_HALF,
  parameter int TMO = dct_pkg::TMO_TICKS
) (
  input wire logic clock, // core clock
  input wire logic rst, // sync reset
  dct_link_if.host lnk, // serial link
  input wire logic req_valid, // request offered
  output logic req_ready, // request taken
  input wire dct_pkg::dct_kind_t req_kind, // transfer kind
  input wire logic [7:0] req_cmd, // command code
  input wire logic [15:0] req_len, // params, null bytes or return size
  input wire logic req_bta, // turn bus after a write
  input wire dct_pkg::dct_err_t req_err, // error marker on command header
  input wire logic [7:0] wr_data, // write parameter byte
  output logic wr_take, // pulse: wr_data consumed
  output logic done, // pulse: transfer over
  output logic ack_seen, // display acknowledged
  output logic [15:0] err_report, // last error report word
  output logic timed_out, // display never gave bus back
  output logic [7:0] rd_byte, // read data
  output logic rd_valid // pulse: rd_byte new
);
  import dct_pkg::*;
  if (HALF < 2 || HALF > 255) begin : g_bad_half
    $error("HALF must be 2..255");
  end
  if (TMO < 1 || TMO > 65535) begin : g_bad_tmo
    $error("TMO must be 1..65535");
  end
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_TX = 3'b001, H_STOP = 3'b011, H_BTA = 3'b010,
    H_WAIT = 3'b110, H_END = 3'b111, H_RST = 3'b100
  } dct_hstate_t;
  dct_hstate_t st;
  dct_seg_t seg;
  dct_kind_t kind;
  dct_err_t err;
  logic [7:0] cnt, cmd, rcnt, tx_byte;
  logic [15:0] len, pos, seg_last, tmo, rpos, rwc;
  logic lclk, tick, bta, writes, sym;
  logic [2:0] dt_sy;
  dct_mode_t dm1, dm;
  logic [7:0] db1, db, rdt, rb1;

  // link clock is a divided copy of the core clock; it runs free after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt <= 8'h00;
      lclk <= 1'b0;
    end else if (cnt == 8'(HALF - 1)) begin
      cnt <= 8'h00;
      lclk <= ~lclk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign lnk.link_clk = lclk;
  // symbols change on the falling link edge, half a period before the device samples
  assign tick = (cnt == 8'(HALF - 1)) && lclk;
  assign writes = (kind == K_WR_LP) || (kind == K_WR_HS);
  assign req_ready = (st == H_IDLE);
  assign wr_take = tick && (st == H_TX) && (seg == S_A) && writes && (pos >= 16'h0004);

  always_comb begin
    seg_last = 16'h0002;
    if (seg == S_A && writes) seg_last = len + 16'h0003;
    if (seg == S_A && kind == K_NULL) seg_last = len + 16'h0002;
    tx_byte = ZERO_BYTE;
    unique case (seg)
      S_A: begin
        if (kind == K_READ) begin
          tx_byte = (pos == 16'h0) ? DT_SET_MAX : (pos == 16'h1) ? len[7:0] : len[15:8];
        end else if (writes) begin
          if (pos == 16'h0) tx_byte = DT_WRITE_LONG;
          else if (pos == 16'h1) tx_byte = 8'(len + 16'h1);
          else if (pos == 16'h2) tx_byte = 8'((len + 16'h1) >> 8);
          else if (pos == 16'h3) tx_byte = cmd;
          else tx_byte = wr_data;
        end else begin
          if (pos == 16'h0) tx_byte = DT_NULL;
          else if (pos == 16'h1) tx_byte = len[7:0];
          else if (pos == 16'h2) tx_byte = len[15:8];
        end
      end
      S_B: tx_byte = (pos == 16'h0) ? DT_READ_NP : (pos == 16'h1) ? cmd : ZERO_BYTE;
      S_EOT: tx_byte = (pos == 16'h0) ? DT_EOT : EOT_FILL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st <= H_RST;
      seg <= S_A;
      pos <= 16'h0000;
      rcnt <= 8'h00;
      tmo <= 16'h0000;
      kind <= K_WR_LP;
      err <= E_NONE;
      cmd <= 8'h00;
      len <= 16'h0000;
      bta <= 1'b0;
      done <= 1'b0;
      timed_out <= 1'b0;
    end else begin
      done <= 1'b0;
      if (st == H_IDLE && req_valid) begin
        st <= H_TX;
        seg <= S_A;
        pos <= 16'h0000;
        kind <= req_kind;
        cmd <= req_cmd;
        len <= req_len;
        err <= req_err;
        bta <= req_bta || (req_kind == K_READ);
        timed_out <= 1'b0;
      end else if (st == H_WAIT && sym && dm == M_BTA) begin
        st <= H_END;
      end else if (tick) begin
        unique case (st)
          H_RST: begin
            rcnt <= rcnt + 8'h01;
            if (rcnt == 8'(RST_TICKS - 1)) st <= H_IDLE;
          end
          H_TX: begin
            pos <= pos + 16'h0001;
            if (pos == seg_last) begin
              pos <= 16'h0000;
              if (seg == S_A && kind == K_READ) seg <= S_B;
              else if (seg == S_EOT || kind == K_WR_LP) st <= H_STOP;
              else seg <= S_EOT;
            end
          end
          H_STOP: begin
            st <= bta ? H_BTA : H_IDLE;
            done <= ~bta;
          end
          H_BTA: begin
            st <= H_WAIT;
            tmo <= 16'h0000;
          end
          H_WAIT: begin
            tmo <= tmo + 16'h0001;
            if (tmo == 16'(TMO - 1)) begin
              st <= H_END;
              timed_out <= 1'b1;
            end
          end
          H_END: begin
            st <= H_IDLE;
            done <= 1'b1;
          end
          default: st <= H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lnk.h_mode <= M_STOP;
      lnk.h_byte <= 8'h00;
      lnk.h_err <= E_NONE;
      lnk.link_rst <= 1'b1;
    end else if (tick) begin
      lnk.link_rst <= (st == H_RST);
      lnk.h_byte <= (st == H_TX) ? tx_byte : 8'h00;
      lnk.h_err <= (st == H_TX && pos == 16'h0 && ((seg == S_A && writes) || seg == S_B))
        ? err : E_NONE;
      unique case (st)
        H_TX: lnk.h_mode <= (kind == K_WR_LP) ? M_LPDT : M_HSDT;
        H_BTA: lnk.h_mode <= M_BTA;
        H_WAIT: lnk.h_mode <= M_REL;
        default: lnk.h_mode <= M_STOP;
      endcase
    end
  end

  // data passes two stages; the toggle a third so the data has settled first
  always_ff @(posedge clock) begin
    if (rst) begin
      dt_sy <= 3'h0;
      dm1 <= M_REL;
      dm <= M_REL;
      db1 <= 8'h00;
      db <= 8'h00;
    end else begin
      dt_sy <= {dt_sy[1:0], lnk.d_tog};
      dm1 <= lnk.d_mode;
      dm <= dm1;
      db1 <= lnk.d_byte;
      db <= db1;
    end
  end
  assign sym = dt_sy[2] ^ dt_sy[1];

  always_ff @(posedge clock) begin
    if (rst) begin
      rpos <= 16'h0000;
      rwc <= 16'h0000;
      rdt <= 8'h00;
      rb1 <= 8'h00;
      rd_byte <= 8'h00;
      rd_valid <= 1'b0;
      ack_seen <= 1'b0;
      err_report <= 16'h0000;
    end else begin
      rd_valid <= 1'b0;
      if (st == H_IDLE && req_valid) begin
        ack_seen <= 1'b0;
        err_report <= 16'h0000;
      end
      if (st == H_WAIT && sym) begin
        if (dm == M_ACK) ack_seen <= 1'b1;
        if (dm != M_LPDT) rpos <= 16'h0000;
        else if (rpos == 16'h0) begin
          rdt <= db;
          rpos <= 16'h0001;
        end else if (rpos == 16'h1) begin
          rb1 <= db;
          rpos <= 16'h0002;
        end else if (rpos == 16'h2) begin
          rpos <= 16'h0000;
          if (rdt == DT_RESP_ONE) begin
            rd_byte <= rb1;
            rd_valid <= 1'b1;
          end
          if (rdt == DT_ACK_ERR) err_report <= {db, rb1};
          if (rdt == DT_RESP_LONG && {db, rb1} != 16'h0) begin
            rwc <= {db, rb1};
            rpos <= 16'h0003;
          end
        end else begin
          rd_byte <= db;
          rd_valid <= 1'b1;
          rpos <= (rpos == rwc + 16'h0002) ? 16'h0000 : rpos + 16'h0001;
        end
      end
    end
  end
endmodule : dct_host_end
`default_nettype wire

// File: dct_pkg.sv
`default_nettype none
package dct_pkg;
  typedef enum logic [2:0] {
    M_REL = 3'h0,
    M_STOP = 3'h1,
    M_LPDT = 3'h2,
    M_HSDT = 3'h3,
    M_BTA = 3'h4,
    M_ACK = 3'h5
  } dct_mode_t;
  typedef enum logic [1:0] {E_NONE = 2'h0, E_COR = 2'h1, E_UNC = 2'h2} dct_err_t;
  typedef enum logic [1:0] {K_WR_LP = 2'h0, K_WR_HS = 2'h1, K_READ = 2'h2, K_NULL = 2'h3} dct_kind_t;
  typedef enum logic [1:0] {P_ACK = 2'h0, P_RESP = 2'h1, P_REP = 2'h3} dct_phase_t;
  typedef enum logic [1:0] {S_A = 2'h0, S_B = 2'h1, S_EOT = 2'h3} dct_seg_t;
  localparam logic [7:0] DT_WRITE_LONG = 8'h39;
  localparam logic [7:0] DT_READ_NP = 8'h06;
  localparam logic [7:0] DT_SET_MAX = 8'h37;
  localparam logic [7:0] DT_EOT = 8'h08;
  localparam logic [7:0] DT_NULL = 8'h09;
  localparam logic [7:0] DT_RESP_ONE = 8'h21;
  localparam logic [7:0] DT_RESP_LONG = 8'h1C;
  localparam logic [7:0] DT_ACK_ERR = 8'h02;
  localparam logic [7:0] EOT_FILL = 8'h0F;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ID_CMD = 8'hDA;
  localparam logic [15:0] MAX_RET_RESET = 16'h0001;
  localparam int ERR_BIT_COR = 8;
  localparam int ERR_BIT_UNC = 9;
  localparam int LINK_HALF = 2;
  localparam int RST_TICKS = 4;
  localparam int TMO_TICKS = 1000;
  localparam int MEM_WORDS = 16;
endpackage : dct_pkg
`default_nettype wire

// File: dct_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dct_link_if;
  logic link_clk;
  logic link_rst;
  dct_pkg::dct_mode_t h_mode;
  logic [7:0] h_byte;
  dct_pkg::dct_err_t h_err;
  dct_pkg::dct_mode_t d_mode;
  logic [7:0] d_byte;
  logic d_tog;
  modport host (
    output link_clk, link_rst, h_mode, h_byte, h_err,
    input d_mode, d_byte, d_tog
  );
  modport device (
    input link_clk, link_rst, h_mode, h_byte, h_err,
    output d_mode, d_byte, d_tog
  );
endinterface : dct_link_if
`default_nettype wire

// File: dct_display_end.sv
`timescale 1ns/100ps
`default_nettype none
module dct_display_end #(
  parameter logic [7:0] ID_VALUE = 8'h5A,
  parameter int MEM_DEPTH = dct_pkg::MEM_WORDS
) (
  input wire logic clock, // core clock
  input wire logic rst, // sync reset, core side
  dct_link_if.device lnk, // serial link
  output logic wr_seen, // pulse: long write taken
  output logic [7:0] wr_cmd // command code of that write
);
  import dct_pkg::*;
  // ID_VALUE is arbitrary, not a real part code
  localparam int AW = $clog2(MEM_DEPTH);
  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (1 << AW) != MEM_DEPTH) begin : g_bad_depth
    $error("MEM_DEPTH must be a power of two, 2..256");
  end
  typedef enum logic [2:0] {
    D_LISTEN = 3'b000, D_TAKE = 3'b001, D_SEND = 3'b011, D_END = 3'b010, D_GIVE = 3'b110
  } dct_dstate_t;
  dct_dstate_t st;
  dct_phase_t ph;
  logic [1:0] rst_sy;
  logic lrst;
  dct_mode_t m1, m2;
  logic [7:0] b1, b2;
  dct_err_t e1, e2;
  logic [15:0] rx_pos, rx_wc, max_ret, tx_idx, tx_last, pay_i, rep;
  logic [7:0] rx_dt, rx_b1, rd_cmd, cmd_hold, rd_data, next_byte;
  logic rx_bad, rd_pend, cor_f, unc_f, wr_tog, long_pkt, rx_data;
  logic short_done, long_done, short_resp, tx_done;
  dct_mode_t next_mode;
  logic [7:0] mem [MEM_DEPTH];
  logic [2:0] wt_sy;
  logic [7:0] cmd_s1, cmd_s2;

  // link reset and host symbols each pass two link-clock stages
  always_ff @(posedge lnk.link_clk) begin
    rst_sy <= {rst_sy[0], lnk.link_rst};
    m1 <= lnk.h_mode;
    m2 <= m1;
    b1 <= lnk.h_byte;
    b2 <= b1;
    e1 <= lnk.h_err;
    e2 <= e1;
  end
  assign lrst = rst_sy[1];

  // receive only while the host owns the link and is sending data
  assign rx_data = (st == D_LISTEN) && (m2 == M_LPDT || m2 == M_HSDT);
  assign long_pkt = (rx_dt == DT_WRITE_LONG) || (rx_dt == DT_NULL);
  assign short_done = rx_data && rx_pos == 16'h0002 && !long_pkt;
  assign pay_i = rx_pos - 16'h0003;
  assign long_done = rx_data && rx_pos >= 16'h0003 && pay_i == rx_wc - 16'h0001;

  always_ff @(posedge lnk.link_clk) begin
    if (lrst) begin
      rx_pos <= 16'h0000;
      rx_dt <= 8'h00;
      rx_b1 <= 8'h00;
      rx_wc <= 16'h0000;
      rx_bad <= 1'b0;
    end else if (!rx_data) begin
      rx_pos <= 16'h0000;
    end else if (rx_pos == 16'h0) begin
      rx_dt <= b2;
      rx_bad <= (e2 == E_UNC);
      rx_pos <= 16'h0001;
    end else if (rx_pos == 16'h1) begin
      rx_b1 <= b2;
      rx_pos <= 16'h0002;
    end else if (rx_pos == 16'h2) begin
      rx_wc <= {b2, rx_b1};
      rx_pos <= (long_pkt && {b2, rx_b1} != 16'h0) ? 16'h0003 : 16'h0000;
    end else begin
      rx_pos <= long_done ? 16'h0000 : rx_pos + 16'h0001;
    end
  end

  // clears come first so that an event in the same cycle still lands
  always_ff @(posedge lnk.link_clk) begin
    if (lrst) begin
      max_ret <= MAX_RET_RESET;
      rd_pend <= 1'b0;
      rd_cmd <= 8'h00;
      cor_f <= 1'b0;
      unc_f <= 1'b0;
      wr_tog <= 1'b0;
      cmd_hold <= 8'h00;
    end else begin
      if (st == D_GIVE) begin
        rd_pend <= 1'b0;
        cor_f <= 1'b0;
        unc_f <= 1'b0;
      end
      if (rx_data && rx_pos == 16'h0 && e2 == E_COR) cor_f <= 1'b1;
      if ((short_done || long_done) && rx_bad) unc_f <= 1'b1;
      if (short_done && !rx_bad && rx_dt == DT_SET_MAX) max_ret <= {b2, rx_b1};
      if (short_done && !rx_bad && rx_dt == DT_READ_NP) begin
        rd_pend <= 1'b1;
        rd_cmd <= rx_b1;
      end
      // an end-of-transmission packet only closes the burst: no flag moves
      if (rx_data && rx_pos == 16'h3 && !rx_bad && rx_dt == DT_WRITE_LONG) cmd_hold <= b2;
      if (long_done && !rx_bad && rx_dt == DT_WRITE_LONG) wr_tog <= ~wr_tog;
    end
  end

  // parameter bytes of a long write fill a small wrapping store
  always_ff @(posedge lnk.link_clk) begin
    if (rx_data && rx_pos >= 16'h4 && !rx_bad && rx_dt == DT_WRITE_LONG) begin
      mem[AW'(rx_pos - 16'h0004)] <= b2;
    end
  end

  assign short_resp = (max_ret <= 16'h0001);
  assign rep = (16'(unc_f) << ERR_BIT_UNC) | (16'(cor_f) << ERR_BIT_COR);

  always_comb begin
    unique case (ph)
      P_ACK: tx_last = 16'h0000;
      P_RESP: tx_last = short_resp ? 16'h0002 : max_ret + 16'h0002;
      P_REP: tx_last = 16'h0002;
      default: tx_last = 16'h0000;
    endcase
  end
  assign tx_done = (tx_idx == tx_last);

  always_ff @(posedge lnk.link_clk) begin
    if (lrst) begin
      st <= D_LISTEN;
      ph <= P_ACK;
      tx_idx <= 16'h0000;
    end else begin
      unique case (st)
        D_LISTEN: if (m2 == M_BTA) st <= D_TAKE;
        D_TAKE: begin
          st <= D_SEND;
          tx_idx <= 16'h0000;
          if (rd_pend && !unc_f) ph <= P_RESP;
          else if (unc_f || cor_f) ph <= P_REP;
          else ph <= P_ACK;
        end
        D_SEND: begin
          tx_idx <= tx_idx + 16'h0001;
          if (tx_done) begin
            tx_idx <= 16'h0000;
            if (ph == P_RESP && cor_f) ph <= P_REP;
            else st <= D_END;
          end
        end
        D_END: st <= D_GIVE;
        D_GIVE: st <= D_LISTEN;
        default: st <= D_LISTEN;
      endcase
    end
  end

  // identification byte answers the DAh read, other reads return written bytes
  always_comb begin
    if (ph == P_RESP && !short_resp) begin
      rd_data = mem[AW'(tx_idx - 16'h0003)];
      if (rd_cmd == ID_CMD && tx_idx == 16'h0003) rd_data = ID_VALUE;
    end else begin
      rd_data = (rd_cmd == ID_CMD) ? ID_VALUE : mem[0];
    end
  end

  always_comb begin
    next_mode = M_REL;
    next_byte = 8'h00;
    unique case (st)
      D_TAKE: next_mode = M_STOP;
      D_SEND: begin
        next_mode = (ph == P_ACK) ? M_ACK : M_LPDT;
        if (ph == P_REP) begin
          if (tx_idx == 16'h0) next_byte = DT_ACK_ERR;
          else next_byte = (tx_idx == 16'h1) ? rep[7:0] : rep[15:8];
        end else if (ph == P_RESP && short_resp) begin
          // channel zero, one data byte, second byte always zero
          if (tx_idx == 16'h0) next_byte = DT_RESP_ONE;
          else next_byte = (tx_idx == 16'h1) ? rd_data : ZERO_BYTE;
        end else if (ph == P_RESP) begin
          if (tx_idx == 16'h0) next_byte = DT_RESP_LONG;
          else if (tx_idx == 16'h1) next_byte = max_ret[7:0];
          else if (tx_idx == 16'h2) next_byte = max_ret[15:8];
          else next_byte = rd_data;
        end
      end
      D_END: next_mode = M_STOP;
      D_GIVE: next_mode = M_BTA;
      default: next_mode = M_REL;
    endcase
  end

  // one symbol per link cycle; the toggle lets the host count them
  always_ff @(posedge lnk.link_clk) begin
    if (lrst) begin
      lnk.d_mode <= M_REL;
      lnk.d_byte <= 8'h00;
      lnk.d_tog <= 1'b0;
    end else begin
      lnk.d_mode <= next_mode;
      lnk.d_byte <= next_byte;
      lnk.d_tog <= ~lnk.d_tog;
    end
  end

  // write event crosses as a toggle; the code is set no later than it flips and crosses one stage sooner
  always_ff @(posedge clock) begin
    if (rst) begin
      wt_sy <= 3'h0;
      cmd_s1 <= 8'h00;
      cmd_s2 <= 8'h00;
      wr_seen <= 1'b0;
      wr_cmd <= 8'h00;
    end else begin
      wt_sy <= {wt_sy[1:0], wr_tog};
      cmd_s1 <= cmd_hold;
      cmd_s2 <= cmd_s1;
      wr_seen <= wt_sy[2] ^ wt_sy[1];
      if (wt_sy[2] ^ wt_sy[1]) wr_cmd <= cmd_s2;
    end
  end
endmodule : dct_display_end
`default_nettype wire

// File: dct_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dct_link_asserts
  import dct_pkg::*;
(
  input wire logic link_clk, // link clock
  input wire logic link_rst, // link reset
  input wire dct_pkg::dct_mode_t h_mode, // host symbol
  input wire logic [7:0] h_byte, // host byte
  input wire dct_pkg::dct_err_t h_err, // header marker
  input wire dct_pkg::dct_mode_t d_mode, // display symbol
  input wire logic [7:0] d_byte, // display byte
  input wire logic d_tog // display symbol toggle
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (link_rst);

  sequence dev_takes;
    $past(d_mode) == M_REL && d_mode != M_REL;
  endsequence
  sequence resp_start;
    d_mode == M_LPDT && $past(d_mode) == M_STOP && d_byte == DT_RESP_ONE;
  endsequence
  // a trailing report may follow the response, otherwise stop
  sequence resp_tail;
    d_mode == M_LPDT ##1 (d_mode == M_LPDT && d_byte == ZERO_BYTE)
      ##1 (d_mode == M_STOP || d_byte == DT_ACK_ERR);
  endsequence

  a_eot_ends_burst: assert property (h_mode == M_STOP && $past(h_mode) == M_HSDT |->
    $past(h_byte, 3) == DT_EOT && $past(h_byte, 2) == EOT_FILL && $past(h_byte) == EOT_FILL)
    else $error("burst ended without end packet");
  a_lp_write_only: assert property (h_mode == M_LPDT && $past(h_mode) == M_STOP |->
    h_byte == DT_WRITE_LONG) else $error("low-power burst is not a long write");
  a_host_turn_stop: assert property (h_mode == M_BTA && $past(h_mode) != M_BTA |->
    $past(h_mode) == M_STOP) else $error("host turn not after stop");
  a_dev_takes_turn: assert property (dev_takes |-> h_mode == M_REL && d_mode == M_STOP)
    else $error("display drove before host release or not stop first");
  a_dev_silent_burst: assert property (h_mode inside {M_LPDT, M_HSDT} |-> d_mode == M_REL)
    else $error("display drove during host burst");
  a_ack_then_turn: assert property (d_mode == M_ACK |=> d_mode == M_STOP ##1 d_mode == M_BTA)
    else $error("ack not followed by stop and turn");
  a_turn_back: assert property (d_mode == M_BTA && $past(d_mode) != M_BTA |->
    $past(d_mode) == M_STOP ##[1:16] d_mode == M_REL) else $error("display turn back broken");
  a_report_alone: assert property (d_mode == M_LPDT && $past(d_mode) == M_STOP &&
    d_byte == DT_ACK_ERR |=> d_mode == M_LPDT ##1 d_mode == M_LPDT ##1 d_mode == M_STOP)
    else $error("error report framing broken");
  a_short_resp_form: assert property (resp_start |=> resp_tail)
    else $error("short response framing broken");
  // the display link logic leaves reset two link cycles after the link reset falls
  a_tog_steps: assert property (!$past(link_rst, 3) |-> d_tog != $past(d_tog))
    else $error("display symbol toggle stalled");
endmodule : dct_link_asserts
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dct_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h5A; // arbitrary identification value
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  dct_kind_t req_kind = K_WR_LP;
  logic [7:0] req_cmd = 8'h00;
  logic [15:0] req_len = 16'h0000;
  logic req_bta = 1'b0;
  dct_err_t req_err = E_NONE;
  logic [7:0] wr_data = 8'hA0;
  logic req_ready, wr_take, done, ack_seen, timed_out, rd_valid, wr_seen;
  logic [15:0] err_report;
  logic [7:0] rd_byte, wr_cmd;
  int mismatches = 0;
  int check_count = 0;
  int seen_cnt = 0;
  logic [7:0] rq[$];
  logic [7:0] hq[$];
  logic [7:0] dq[$];
  logic dev_spoke = 1'b0;
  dct_link_if lnk ();
  initial forever #20 clock = ~clock;
  dct_host_end dct_host_end_inst (.clock(clock), .rst(rst), .lnk(lnk), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_cmd(req_cmd), .req_len(req_len),
    .req_bta(req_bta), .req_err(req_err), .wr_data(wr_data), .wr_take(wr_take), .done(done),
    .ack_seen(ack_seen), .err_report(err_report), .timed_out(timed_out), .rd_byte(rd_byte),
    .rd_valid(rd_valid));
  dct_display_end #(.ID_VALUE(ID_VAL)) dct_display_end_inst (.clock(clock), .rst(rst),
    .lnk(lnk), .wr_seen(wr_seen), .wr_cmd(wr_cmd));
  dct_link_asserts dct_link_asserts_inst (.link_clk(lnk.link_clk), .link_rst(lnk.link_rst),
    .h_mode(lnk.h_mode), .h_byte(lnk.h_byte), .h_err(lnk.h_err), .d_mode(lnk.d_mode),
    .d_byte(lnk.d_byte), .d_tog(lnk.d_tog));
  // parameter bytes count up from A0 each time one is consumed
  always @(posedge clock) if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
  always @(posedge clock) if (wr_seen === 1'b1) seen_cnt++;
  always @(posedge lnk.link_clk) if (lnk.h_mode == M_HSDT) hq.push_back(lnk.h_byte);
  // display changes on the rising edge, so look at it on the falling one
  always @(negedge lnk.link_clk) begin
    if (lnk.d_mode == M_LPDT) dq.push_back(lnk.d_byte);
    if (lnk.d_mode != M_REL) dev_spoke = 1'b1;
  end

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_q(string what, logic [7:0] exp[$], logic [7:0] got[$]);
    chk({what, " count"}, 16'(exp.size()), 16'(got.size()));
    foreach (exp[i]) if (i < got.size()) chk(what, {8'h00, exp[i]}, {8'h00, got[i]});
  endtask : chk_q
  task automatic do_req(dct_kind_t k, logic [7:0] c, logic [15:0] n, logic b, dct_err_t e);
    int t;
    t = 0;
    @(posedge clock);
    rq.delete();
    hq.delete();
    dq.delete();
    dev_spoke = 1'b0;
    req_valid <= 1'b1;
    req_kind <= k;
    req_cmd <= c;
    req_len <= n;
    req_bta <= b;
    req_err <= e;
    wr_data <= 8'hA0;
    do begin @(posedge clock); t++; end while (req_ready !== 1'b1 && t < 400);
    if (req_ready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    req_valid <= 1'b0;
    do begin
      @(posedge clock);
      t++;
      if (rd_valid === 1'b1) rq.push_back(rd_byte);
    end while (done !== 1'b1 && t < 20000);
    if (t >= 20000) begin
      mismatches++;
      end_sim();
    end
  endtask : do_req
  task automatic wait_seen(int n, logic [7:0] c);
    int t;
    t = 0;
    while (seen_cnt < n && t < 200) begin @(posedge clock); t++; end
    if (t >= 200) begin
      mismatches++;
      end_sim();
    end
    chk("writes taken", 16'(n), 16'(seen_cnt));
    chk("write command", {8'h00, c}, {8'h00, wr_cmd});
  endtask : wait_seen
  task automatic chk_eot();
    chk("end type", {8'h00, DT_EOT}, {8'h00, hq[hq.size() - 3]});
    chk("end fill", {EOT_FILL, EOT_FILL}, {hq[hq.size() - 2], hq[hq.size() - 1]});
  endtask : chk_eot

  task automatic t_writes();
    do_req(K_WR_LP, 8'h2C, 16'h0003, 1'b0, E_NONE);
    chk("high-speed bytes", 16'h0000, 16'(hq.size()));
    chk("display spoke", 16'h0000, {15'h0000, dev_spoke});
    wait_seen(1, 8'h2C);
    do_req(K_WR_HS, 8'h3A, 16'h0004, 1'b0, E_NONE);
    chk_eot();
    chk("display spoke", 16'h0000, {15'h0000, dev_spoke});
    wait_seen(2, 8'h3A);
  endtask : t_writes
  task automatic t_write_turn();
    dct_err_t e;
    for (int i = 0; i < 3; i++) begin
      e = dct_err_t'(i);
      do_req(K_WR_HS, 8'h2C, 16'h0002, 1'b1, e);
      chk("ack seen", {15'h0000, e == E_NONE}, {15'h0000, ack_seen});
      chk("error report", {6'h00, e == E_UNC, e == E_COR, 8'h00}, err_report);
      chk("timed out", 16'h0000, {15'h0000, timed_out});
    end
  endtask : t_write_turn
  task automatic t_read_id();
    dct_err_t e;
    for (int i = 0; i < 3; i++) begin
      e = dct_err_t'(i);
      do_req(K_READ, ID_CMD, 16'h0001, 1'b0, e);
      if (e == E_NONE) begin
        chk_q("host bytes", '{DT_SET_MAX, 8'h01, ZERO_BYTE, DT_READ_NP, ID_CMD, ZERO_BYTE,
          DT_EOT, EOT_FILL, EOT_FILL}, hq);
        chk_q("display bytes", '{DT_RESP_ONE, ID_VAL, ZERO_BYTE}, dq);
        chk_q("read data", '{ID_VAL}, rq);
      end else if (e == E_COR) begin
        chk_q("display bytes", '{DT_RESP_ONE, ID_VAL, ZERO_BYTE, DT_ACK_ERR, 8'h00, 8'h01},
          dq);
        chk_q("read data", '{ID_VAL}, rq);
      end else begin
        chk_q("display bytes", '{DT_ACK_ERR, 8'h00, 8'h02}, dq);
        chk("read count", 16'h0000, 16'(rq.size()));
      end
      chk("error report", {6'h00, e == E_UNC, e == E_COR, 8'h00}, err_report);
    end
  endtask : t_read_id
  task automatic t_read_long();
    int base;
    base = seen_cnt;
    do_req(K_WR_LP, 8'h2C, 16'h0004, 1'b0, E_NONE);
    wait_seen(base + 1, 8'h2C);
    do_req(K_READ, 8'h2E, 16'h0004, 1'b0, E_NONE);
    chk_q("long response", '{DT_RESP_LONG, 8'h04, 8'h00, 8'hA0, 8'hA1, 8'hA2, 8'hA3}, dq);
    chk_q("read data", '{8'hA0, 8'hA1, 8'hA2, 8'hA3}, rq);
  endtask : t_read_long
  task automatic t_null();
    int base;
    base = seen_cnt;
    do_req(K_NULL, 8'h00, 16'h0005, 1'b0, E_NONE);
    chk("null type", {8'h00, DT_NULL}, {8'h00, hq[0]});
    chk_eot();
    chk("display spoke", 16'h0000, {15'h0000, dev_spoke});
    // a wrongly taken write needs a few cycles to cross into the core domain
    repeat (40) @(posedge clock);
    chk("writes taken", 16'(base), 16'(seen_cnt));
  endtask : t_null

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_writes();
    t_write_turn();
    t_read_id();
    t_read_long();
    t_null();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
